/* hdl/wdck_top.sv */
// Notes on behaviour
// - service needs first key then second key
// - out-of-order key write forces immediate timeout
// - service key field resets to zero
// - keys ignored outside watchdog mode
// - flag reads one after a timeout
// - flag cleared on activation, reset, write-one
// - enable bit moves initial to pre-active
// - enable clear: pin disconnected, plain timer
// - enable set: pin follows timeout event
// - enable cleared only by timeout or reset
// - idle allowed after idle keys one, two
// - idle key zero blocks idle mode
// - low twelve bits read zero, ignore writes
// - watchdog applies when mode selects watchdog
// - run bits frozen while watchdog active
`timescale 1ns/1ps
`include "wdck_regs.svh"
module wdck_top import wdck_pkg::*; (
    input wire logic aclk, // 10 MHz clock
    input wire logic aresetn, // sync reset, low
    input wire wdck_addr_t awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire wdck_addr_t araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic [1:0] timer_mode_select, // global mode field
    input wire logic count_expired, // counter reached period
    input wire logic low_half_run_in, // requested low run bit
    input wire logic high_half_run_in, // requested high run bit
    output logic low_half_run, // effective low run bit
    output logic high_half_run, // effective high run bit
    output logic wd_out, // watchdog output pin
    output logic gp_mode, // counter runs as plain timer
    output logic idle_allowed, // idle entry permitted
    output logic service_pulse, // counter reload pulse
    output logic irq // level interrupt
);
    localparam wdck_core_s CORE_RST = '{
        state: st_init,
        key: `WDCK_KEY_RST,
        idle_key: `WDCK_IDLE_RST,
        irq_status: `WDCK_IRQ_RST,
        irq_mask: `WDCK_IRQ_RST,
        gp_mode: 1'b1,
        default: '0
    };

    wdck_core_s r;
    wdck_core_s n;
    wdck_bus_if bus ();

    logic wd_mode;
    logic armed;
    logic ctrl_wr;
    logic stat_rd;
    logic mask_wr;
    logic key_wr;
    logic idle_wr;
    logic en_wr;
    logic flag_clr;
    logic key_good;
    logic key_bad;
    logic timeout;
    logic [1:0] events;
    logic [31:0] ctrl_view;

    wdck_axi_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .bus(bus.slave)
    );

    wdck_key_check u_keys (
        .aclk(aclk),
        .aresetn(aresetn),
        .key_wr(key_wr),
        .key_val(bus.wr_data[`WDCK_KEY_MSB:`WDCK_KEY_LSB]),
        .armed(armed),
        .key_good(key_good),
        .key_bad(key_bad)
    );

    // decode of register strobes
    always_comb
    begin
        wd_mode = timer_mode_select == `WDCK_MODE_WD;
        armed = wd_mode && r.enable && r.state != st_init;
        ctrl_wr = bus.wr_en && bus.wr_addr == `WDCK_OFF_CTRL;
        mask_wr = bus.wr_en && bus.wr_addr == `WDCK_OFF_MASK && bus.wr_strb[0];
        stat_rd = bus.rd_en && bus.rd_addr == `WDCK_OFF_STAT;
        // the key counts as written only when both upper byte lanes are
        key_wr = ctrl_wr && bus.wr_strb[3] && bus.wr_strb[2];
        idle_wr = ctrl_wr && bus.wr_strb[1] && wd_mode;
        en_wr = ctrl_wr && bus.wr_strb[1] && wd_mode && bus.wr_data[`WDCK_EN_BIT];
        flag_clr = ctrl_wr && bus.wr_strb[1] && bus.wr_data[`WDCK_FLAG_BIT];
        timeout = key_bad || (wd_mode && r.state == st_active && count_expired);
        events = '0;
        events[`WDCK_IRQ_TIMEOUT] = timeout;
        events[`WDCK_IRQ_SERVICE] = key_good && r.state == st_active;
        ctrl_view = {r.key, r.flag, r.enable, r.idle_key, 12'h000};
    end

    // register read side and error answers
    always_comb
    begin
        bus.rd_err = 1'b0;
        unique case (bus.rd_addr)
            `WDCK_OFF_CTRL:
                bus.rd_data = ctrl_view;
            `WDCK_OFF_STAT:
                bus.rd_data = {30'h0000_0000, r.irq_status};
            `WDCK_OFF_MASK:
                bus.rd_data = {30'h0000_0000, r.irq_mask};
            default:
            begin
                bus.rd_data = 32'h0000_0000;
                bus.rd_err = 1'b1;
            end
        endcase
        bus.wr_err = !(bus.wr_addr == `WDCK_OFF_CTRL || bus.wr_addr == `WDCK_OFF_STAT
            || bus.wr_addr == `WDCK_OFF_MASK);
    end

    // next state of the control logic
    always_comb
    begin
        n = r;
        n.service = events[`WDCK_IRQ_SERVICE];
        if (key_wr)
            n.key = bus.wr_data[`WDCK_KEY_MSB:`WDCK_KEY_LSB];
        if (idle_wr)
        begin
            n.idle_key = bus.wr_data[`WDCK_IDLE_MSB:`WDCK_IDLE_LSB];
            n.idle_half = 1'b0;
            if (n.idle_key == `WDCK_IDLE_FIRST)
                n.idle_half = 1'b1;
            else if (n.idle_key == `WDCK_IDLE_SECOND && r.idle_half)
                n.idle_ok = 1'b1;
            else if (n.idle_key == `WDCK_IDLE_BLOCK)
                n.idle_ok = 1'b0;
        end
        if (en_wr)
            n.enable = 1'b1;
        if (flag_clr)
            n.flag = 1'b0;
        unique case (r.state)
            st_init:
                if (r.enable && wd_mode)
                    n.state = st_preact;
            st_preact:
                if (key_good)
                begin
                    n.state = st_active;
                    n.flag = 1'b0;
                end
            st_active:
                if (!wd_mode)
                    n.state = st_init;
            default:
                n.state = st_init;
        endcase
        // a timeout wins over a software clear in the same cycle
        if (timeout)
        begin
            n.flag = 1'b1;
            n.enable = 1'b0;
            n.state = st_init;
        end
        n.wd_out = r.enable && timeout;
        n.gp_mode = !n.enable || !wd_mode;
        if (r.state != st_active)
        begin
            n.lo_run = low_half_run_in;
            n.hi_run = high_half_run_in;
        end
        if (stat_rd)
            n.irq_status = '0;
        n.irq_status = n.irq_status | events;
        if (mask_wr)
            n.irq_mask = bus.wr_data[1:0];
        n.irq = |(n.irq_status & n.irq_mask);
    end

    always_ff @(posedge aclk)
        if (!aresetn)
            r <= CORE_RST;
        else
            r <= n;

    assign low_half_run = r.lo_run;
    assign high_half_run = r.hi_run;
    assign wd_out = r.wd_out;
    assign gp_mode = r.gp_mode;
    assign idle_allowed = r.idle_ok;
    assign service_pulse = r.service;
    assign irq = r.irq;

    property p_bad_key_times_out;
        @(posedge aclk) disable iff (!aresetn)
        key_bad |=> r.flag && !r.enable && r.state == st_init;
    endproperty
    a_bad_key_times_out: assert property (p_bad_key_times_out) else $error("wrong key did not time out");

    property p_key_reset;
        @(posedge aclk)
        !aresetn |=> r.key == `WDCK_KEY_RST && r.state == st_init && !r.flag;
    endproperty
    a_key_reset: assert property (p_key_reset) else $error("key field not zero after reset");

    property p_gp_ignores_keys;
        @(posedge aclk) disable iff (!aresetn)
        !wd_mode |-> !key_good && !key_bad && !timeout;
    endproperty
    a_gp_ignores_keys: assert property (p_gp_ignores_keys) else $error("key acted in plain timer mode");

    property p_flag_holds;
        @(posedge aclk) disable iff (!aresetn)
        r.flag && !flag_clr && !(r.state == st_preact && key_good) |=> r.flag;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("timeout flag lost");

    property p_flag_clear_on_active;
        @(posedge aclk) disable iff (!aresetn)
        r.state == st_preact && key_good |=> !r.flag && r.state == st_active;
    endproperty
    a_flag_clear_on_active: assert property (p_flag_clear_on_active) else $error("flag kept on activation");

    property p_flag_w1c;
        @(posedge aclk) disable iff (!aresetn)
        flag_clr && !timeout |=> !r.flag;
    endproperty
    a_flag_w1c: assert property (p_flag_w1c) else $error("write one did not clear flag");

    property p_init_needs_enable;
        @(posedge aclk) disable iff (!aresetn)
        r.state == st_init && !r.enable |=> r.state == st_init;
    endproperty
    a_init_needs_enable: assert property (p_init_needs_enable) else $error("left initial state without enable");

    property p_enable_to_preact;
        @(posedge aclk) disable iff (!aresetn)
        r.state == st_init && en_wr && !timeout ##1 wd_mode |=> r.state == st_preact;
    endproperty
    a_enable_to_preact: assert property (p_enable_to_preact) else $error("enable did not reach pre-active");

    property p_disabled_pin_quiet;
        @(posedge aclk) disable iff (!aresetn)
        !r.enable |=> !r.wd_out && r.gp_mode == !r.enable;
    endproperty
    a_disabled_pin_quiet: assert property (p_disabled_pin_quiet) else $error("pin driven while disabled");

    property p_pin_follows_timeout;
        @(posedge aclk) disable iff (!aresetn)
        r.enable && timeout |=> r.wd_out ##1 !r.wd_out;
    endproperty
    a_pin_follows_timeout: assert property (p_pin_follows_timeout) else $error("pin missed timeout");

    property p_enable_sticky;
        @(posedge aclk) disable iff (!aresetn)
        r.enable && !timeout |=> r.enable;
    endproperty
    a_enable_sticky: assert property (p_enable_sticky) else $error("enable cleared without timeout");

    property p_idle_sequence;
        @(posedge aclk) disable iff (!aresetn)
        idle_wr && r.idle_half && bus.wr_data[`WDCK_IDLE_MSB:`WDCK_IDLE_LSB] == `WDCK_IDLE_SECOND |=> idle_allowed;
    endproperty
    a_idle_sequence: assert property (p_idle_sequence) else $error("idle key pair not accepted");

    property p_idle_block;
        @(posedge aclk) disable iff (!aresetn)
        idle_wr && bus.wr_data[`WDCK_IDLE_MSB:`WDCK_IDLE_LSB] == `WDCK_IDLE_BLOCK |=> !idle_allowed;
    endproperty
    a_idle_block: assert property (p_idle_block) else $error("idle still allowed after block");

    property p_reserved_zero;
        @(posedge aclk) disable iff (!aresetn)
        bus.rd_en && bus.rd_addr == `WDCK_OFF_CTRL |=> rvalid && rdata[`WDCK_RSVD_MSB:0] == 12'h000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_run_frozen;
        @(posedge aclk) disable iff (!aresetn)
        r.state == st_active |=> $stable(low_half_run) && $stable(high_half_run);
    endproperty
    a_run_frozen: assert property (p_run_frozen) else $error("run bit changed while active");

    property p_irq_timeout;
        @(posedge aclk) disable iff (!aresetn)
        timeout && r.irq_mask[`WDCK_IRQ_TIMEOUT] && !mask_wr |=> irq;
    endproperty
    a_irq_timeout: assert property (p_irq_timeout) else $error("unmasked timeout gave no interrupt");

    property p_service_pulse;
        @(posedge aclk) disable iff (!aresetn)
        r.state == st_active && key_good |=> service_pulse ##1 !service_pulse;
    endproperty
    a_service_pulse: assert property (p_service_pulse) else $error("service pulse wrong");

    property p_run_follows;
        @(posedge aclk) disable iff (!aresetn)
        r.state != st_active |=> low_half_run == $past(low_half_run_in) && high_half_run == $past(high_half_run_in);
    endproperty
    a_run_follows: assert property (p_run_follows) else $error("run bit did not follow request");

    property p_enable_only_wd;
        @(posedge aclk) disable iff (!aresetn)
        !wd_mode && !r.enable |=> !r.enable;
    endproperty
    a_enable_only_wd: assert property (p_enable_only_wd) else $error("enable set in plain timer mode");

    property p_idle_plain;
        @(posedge aclk) disable iff (!aresetn)
        !wd_mode |=> $stable(idle_allowed);
    endproperty
    a_idle_plain: assert property (p_idle_plain) else $error("idle key acted in plain timer mode");

    property p_leave_wd_mode;
        @(posedge aclk) disable iff (!aresetn)
        r.state == st_active && !wd_mode |=> r.state == st_init && !wd_out;
    endproperty
    a_leave_wd_mode: assert property (p_leave_wd_mode) else $error("active kept outside watchdog mode");
endmodule // wdck_top

/* inc/wdck_regs.svh */
`ifndef WDCK_REGS_SVH
`define WDCK_REGS_SVH
`define WDCK_OFF_CTRL 8'h00
`define WDCK_OFF_STAT 8'h04
`define WDCK_OFF_MASK 8'h08
`define WDCK_KEY_MSB 31
`define WDCK_KEY_LSB 16
`define WDCK_FLAG_BIT 15
`define WDCK_EN_BIT 14
`define WDCK_IDLE_MSB 13
`define WDCK_IDLE_LSB 12
`define WDCK_RSVD_MSB 11
`define WDCK_KEY_FIRST 16'ha5c6
`define WDCK_KEY_SECOND 16'hda7e
`define WDCK_IDLE_FIRST 2'h1
`define WDCK_IDLE_SECOND 2'h2
`define WDCK_IDLE_BLOCK 2'h0
`define WDCK_MODE_WD 2'h2
`define WDCK_KEY_RST 16'h0000
`define WDCK_IDLE_RST 2'h0
`define WDCK_IRQ_RST 2'h0
`define WDCK_IRQ_TIMEOUT 0
`define WDCK_IRQ_SERVICE 1
`define WDCK_RESP_OKAY 2'h0
`define WDCK_RESP_SLVERR 2'h2
`endif

/* inc/wdck_pkg.sv */
package wdck_pkg;
    typedef logic [7:0] wdck_addr_t;
    typedef enum logic [2:0] {
        st_init = 3'b001,
        st_preact = 3'b010,
        st_active = 3'b100
    } wdck_state_e;
    typedef struct packed {
        logic expect_second;
    } wdck_key_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        wdck_addr_t aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wdck_axi_s;
    typedef struct packed {
        wdck_state_e state;
        logic enable;
        logic flag;
        logic [15:0] key;
        logic [1:0] idle_key;
        logic idle_half;
        logic idle_ok;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic irq;
        logic wd_out;
        logic gp_mode;
        logic lo_run;
        logic hi_run;
        logic service;
    } wdck_core_s;
endpackage

/* inc/wdck_bus_if.sv */
`timescale 1ns/1ps
interface wdck_bus_if;
    import wdck_pkg::*;
    logic wr_en;
    wdck_addr_t wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    wdck_addr_t rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_err, rd_data, rd_err);
    modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_err, rd_data, rd_err);
endinterface

/* hdl/wdck_key_check.sv */
`timescale 1ns/1ps
`include "wdck_regs.svh"
module wdck_key_check import wdck_pkg::*; (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low
    input wire logic key_wr, // key field written
    input wire logic [15:0] key_val, // written key
    input wire logic armed, // key checking live
    output logic key_good, // pair completed
    output logic key_bad // order broken
);
    wdck_key_s r;
    wdck_key_s n;

    always_comb
    begin
        n = r;
        key_good = 1'b0;
        key_bad = 1'b0;
        if (!armed)
            n.expect_second = 1'b0;
        else if (key_wr)
        begin
            if (!r.expect_second && key_val == `WDCK_KEY_FIRST)
                n.expect_second = 1'b1;
            else if (r.expect_second && key_val == `WDCK_KEY_SECOND)
            begin
                n.expect_second = 1'b0;
                key_good = 1'b1;
            end
            else
            begin
                n.expect_second = 1'b0;
                key_bad = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
        if (!aresetn)
            r <= '0;
        else
            r <= n;

    property p_pair_services;
        @(posedge aclk) disable iff (!aresetn)
        armed && key_wr && r.expect_second && key_val == `WDCK_KEY_SECOND |-> key_good ##1 !r.expect_second;
    endproperty
    a_pair_services: assert property (p_pair_services) else $error("key pair not accepted");

    property p_fresh_pair;
        @(posedge aclk) disable iff (!aresetn)
        armed && key_wr && !r.expect_second && key_val == `WDCK_KEY_SECOND |-> key_bad;
    endproperty
    a_fresh_pair: assert property (p_fresh_pair) else $error("lone second key accepted");
endmodule // wdck_key_check

/* hdl/wdck_axi_slave.sv */
`timescale 1ns/1ps
`include "wdck_regs.svh"
module wdck_axi_slave import wdck_pkg::*; (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low
    input wire wdck_addr_t awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire wdck_addr_t araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    wdck_bus_if.slave bus // register strobes
);
    localparam wdck_axi_s AXI_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
    wdck_axi_s r;
    wdck_axi_s n;

    assign bus.wr_en = r.aw_got && r.w_got && !r.bvalid;
    assign bus.wr_addr = r.aw_addr;
    assign bus.wr_data = r.wdata;
    assign bus.wr_strb = r.wstrb;
    assign bus.rd_en = arvalid && r.arready;
    assign bus.rd_addr = araddr;

    always_comb
    begin
        n = r;
        if (awvalid && r.awready)
        begin
            n.aw_got = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && r.wready)
        begin
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (r.bvalid && bready)
            n.bvalid = 1'b0;
        if (bus.wr_en)
        begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = bus.wr_err ? `WDCK_RESP_SLVERR : `WDCK_RESP_OKAY;
        end
        if (r.rvalid && rready)
            n.rvalid = 1'b0;
        if (bus.rd_en)
        begin
            n.rvalid = 1'b1;
            n.rdata = bus.rd_data;
            n.rresp = bus.rd_err ? `WDCK_RESP_SLVERR : `WDCK_RESP_OKAY;
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge aclk)
        if (!aresetn)
            r <= AXI_RST;
        else
            r <= n;

    assign awready = r.awready;
    assign wready = r.wready;
    assign bresp = r.bresp;
    assign bvalid = r.bvalid;
    assign arready = r.arready;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign rvalid = r.rvalid;
endmodule // wdck_axi_slave

/* verif/wdck_top_tb.sv */
`timescale 1ns/1ps
module wdck_top_tb;
import wdck_pkg::*;
logic aclk = 1'b0;
logic aresetn = 1'b0;
wdck_addr_t awaddr = 8'h00, araddr = 8'h00;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
logic [31:0] wdata = 32'h0000_0000;
logic [3:0] wstrb = 4'h0;
logic [1:0] mode = 2'h0;
logic cexp = 1'b0, lo_in = 1'b0, hi_in = 1'b0;
logic awready, wready, bvalid, arready, rvalid, lo_run, hi_run, wd_out, gp_mode, idle_ok, svc, irq;
logic [1:0] bresp, rresp, resp;
logic [31:0] rdata, got, rnd = 32'h0000_9893;
int n_mismatch = 0, cmp_count = 0, n_svc = 0, n_wdo = 0;
// reference model of the control register and watchdog state
int m_svc = 0, m_wdo = 0, m_st = 0;
logic [15:0] m_key = 16'h0000;
logic m_flag = 1'b0, m_en = 1'b0, m_sec = 1'b0, m_half = 1'b0, m_idle_ok = 1'b0;
logic [1:0] m_idle = 2'h0, m_stat = 2'h0, m_mask = 2'h0;

always #50 aclk = ~aclk;

wdck_top i_wdck_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .timer_mode_select(mode), .count_expired(cexp),
    .low_half_run_in(lo_in), .high_half_run_in(hi_in), .low_half_run(lo_run), .high_half_run(hi_run),
    .wd_out(wd_out), .gp_mode(gp_mode), .idle_allowed(idle_ok), .service_pulse(svc), .irq(irq));

always @(posedge aclk)
begin
    if (svc === 1'b1) n_svc++;
    if (wd_out === 1'b1) n_wdo++;
end

function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction

task chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
        n_mismatch++;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
endtask

task chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
        n_mismatch++;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
endtask

task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask

task m_timeout;
    m_flag = 1'b1;
    m_en = 1'b0;
    m_st = 0;
    m_sec = 1'b0;
    m_wdo++;
    m_stat[0] = 1'b1;
endtask

task m_write(input wdck_addr_t a, input logic [31:0] d, input logic [3:0] s);
    if (a == 8'h08 && s[0]) m_mask = d[1:0];
    if (a != 8'h00) return;
    if (s[1])
    begin
        if (d[15]) m_flag = 1'b0;
        if (d[14] && mode == 2'h2) m_en = 1'b1;
        if (m_en && m_st == 0) m_st = 1;
        if (mode == 2'h2)
        begin
            m_idle = d[13:12];
            if (d[13:12] == 2'h0) m_idle_ok = 1'b0;
            if (d[13:12] == 2'h2 && m_half) m_idle_ok = 1'b1;
            m_half = (d[13:12] == 2'h1);
        end
    end
    if (s[3] && s[2])
    begin
        m_key = d[31:16];
        if (mode == 2'h2 && m_st != 0)
        begin
            if (!m_sec && m_key == 16'ha5c6) m_sec = 1'b1;
            else if (m_sec && m_key == 16'hda7e)
            begin
                m_sec = 1'b0;
                if (m_st == 2) m_svc++;
                if (m_st == 2) m_stat[1] = 1'b1;
                m_st = 2;
                m_flag = 1'b0;
            end
            else m_timeout;
        end
    end
endtask

task axw(input wdck_addr_t a, input logic [31:0] d, input logic [3:0] s);
    bit done;
    int n;
    done = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && !done; n++)
    begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        done = bvalid;
        resp = bresp;
    end
    bready <= 1'b0;
    if (!done) n_mismatch++;
    chk_word({30'h0000_0000, resp}, (a == 8'h00 || a == 8'h04 || a == 8'h08) ? 32'h0000_0000 : 32'h0000_0002);
    m_write(a, d, s);
    @(posedge aclk);
endtask

task axr(input wdck_addr_t a);
    bit done;
    int n;
    done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && !done; n++)
    begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        done = rvalid;
        got = rdata;
        resp = rresp;
    end
    rready <= 1'b0;
    if (!done) n_mismatch++;
    @(posedge aclk);
endtask

task all_chk;
    axr(8'h00);
    chk_word({30'h0000_0000, resp}, 32'h0000_0000);
    chk_word(got, {m_key, m_flag, m_en, m_idle, 12'h000});
    chk_bit(gp_mode, !(m_en && mode == 2'h2));
    chk_bit(idle_ok, m_idle_ok);
    chk_word(32'(n_svc), 32'(m_svc));
    chk_word(32'(n_wdo), 32'(m_wdo));
    chk_bit(irq, |(m_stat & m_mask));
endtask

task stat_chk;
    axr(8'h04);
    chk_word(got, {30'h0000_0000, m_stat});
    m_stat = 2'h0;
endtask

initial
begin
    #(100 * 5000);
    n_mismatch++;
    wrap_up;
end

initial
begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    all_chk;
    stat_chk;
    $display("reset test done");
    rnd = lfsr(rnd);
    mode <= {rnd[2], 1'b1};
    axw(8'h00, rnd | 32'h0000_4000, 4'hf);
    all_chk;
    $display("plain timer test done");
    mode <= 2'h2;
    axw(8'h08, 32'h0000_0001, 4'h1);
    axw(8'h00, 32'h0000_4000, 4'h3);
    axw(8'h00, 32'h0000_0000, 4'h3);
    all_chk;
    axw(8'h00, 32'ha5c6_0000, 4'hc);
    axw(8'h00, 32'hda7e_0000, 4'hc);
    lo_in <= 1'b1;
    hi_in <= 1'b1;
    axw(8'h00, 32'ha5c6_0000, 4'hc);
    axw(8'h00, 32'hda7e_0000, 4'hc);
    chk_bit(lo_run, 1'b0);
    chk_bit(hi_run, 1'b0);
    all_chk;
    $display("service test done");
    axw(8'h00, 32'h1234_0000, 4'hc);
    all_chk;
    chk_bit(lo_run, 1'b1);
    chk_bit(hi_run, 1'b1);
    stat_chk;
    axw(8'h00, 32'h0000_4000, 4'h3);
    axw(8'h00, 32'ha5c6_0000, 4'hc);
    axw(8'h00, 32'ha5c6_0000, 4'hc);
    all_chk;
    axw(8'h00, 32'h0000_4000, 4'h3);
    axw(8'h00, 32'hda7e_0000, 4'hc);
    all_chk;
    $display("bad key test done");
    axw(8'h00, 32'h0000_4000, 4'h3);
    axw(8'h00, 32'ha5c6_0000, 4'hc);
    axw(8'h00, 32'hda7e_0000, 4'hc);
    all_chk;
    cexp <= 1'b1;
    @(posedge aclk);
    cexp <= 1'b0;
    repeat (3) @(posedge aclk);
    m_timeout;
    all_chk;
    axw(8'h00, 32'h0000_0000, 4'h3);
    all_chk;
    axw(8'h00, 32'h0000_8000, 4'h3);
    all_chk;
    $display("flag test done");
    axw(8'h00, 32'h0000_5000, 4'h3);
    axw(8'h00, 32'h0000_6000, 4'h3);
    all_chk;
    axw(8'h00, 32'h0000_4000, 4'h3);
    all_chk;
    $display("idle key test done");
    axw(8'h00, 32'ha5c6_0000, 4'hc);
    axw(8'h00, 32'hda7e_0000, 4'hc);
    mode <= 2'h0;
    @(posedge aclk);
    m_st = 0;
    all_chk;
    $display("mode leave test done");
    axr(8'h0c);
    chk_word({30'h0000_0000, resp}, 32'h0000_0002);
    chk_word(got, 32'h0000_0000);
    rnd = lfsr(rnd);
    axw(8'h0c, rnd, 4'hf);
    chk_word({30'h0000_0000, resp}, 32'h0000_0002);
    all_chk;
    $display("unmapped test done");
    wrap_up;
end
endmodule // wdck_top_tb
